// >>> src/rhcpa_pkg.sv
// Package for the receive HDLC channel provisioning indirect access block.
// Assumes a single 10 MHz clock domain and an AXI4-Lite register bus.
package rhcpa_pkg;
  localparam logic [11:0] RHCPA_SEL_OFF   = 12'h200;
  localparam logic [11:0] RHCPA_DATA1_OFF = 12'h204;
  localparam logic [11:0] RHCPA_TRANSFER_SIZE_OFF  = 12'h208;
  localparam int RHCPA_CHANNEL_NUMBER_LSB   = 0;
  localparam int RHCPA_DIR_BIT    = 14;
  localparam int RHCPA_BUSY_BIT   = 15;
  localparam int RHCPA_FIFO_BLOCK_POINTER_LSB   = 0;
  localparam int RHCPA_TRANSFER_AVAILABLE_BIT = 10;
  localparam int RHCPA_DELINEATE_ENABLE_BIT  = 11;
  localparam int RHCPA_FCS_DISCARD_BIT  = 12;
  localparam int RHCPA_CRC_LSB    = 13;
  localparam int RHCPA_PROVISION_ENABLE_BIT   = 15;
  localparam int RHCPA_ACCESS_CYCLES = 2;
  localparam int RHCPA_BLOCK_BYTES   = 16;
  localparam logic [1:0] RHCPA_RESP_OKAY   = 2'b00;
  localparam logic [1:0] RHCPA_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    RHCPA_CRC_NONE  = 2'b00,
    RHCPA_CRC_CCITT = 2'b01,
    RHCPA_CRC_32    = 2'b10,
    RHCPA_CRC_RSVD  = 2'b11
  } rhcpa_crc_t;
  typedef struct packed {
    logic       provision_enable;
    rhcpa_crc_t crc;
    logic       fcs_discard;
    logic       delineate_enable;
    logic [8:0] fifo_block_pointer;
  } rhcpa_entry_t;
  localparam rhcpa_entry_t RHCPA_ENTRY_RST = '{provision_enable: 1'b0, crc: RHCPA_CRC_NONE, fcs_discard: 1'b0,
                                               delineate_enable: 1'b0, fifo_block_pointer: 9'h000};
  typedef struct packed {
    logic       enable;
    logic       delineate;
    rhcpa_crc_t crc_check;
    logic       discard_fcs;
  } rhcpa_ctrl_t;
endpackage : rhcpa_pkg

// >>> src/rhcpa_top.sv
// Indirect access port to the receive HDLC channel provisioning memory.
// Assumes one clock, synchronous active-low reset and an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - A select register write with byte strobes 0 and 1 set, while not busy, launches one indirect access to the channel.
// - A five-bit channel number picks the provisioning entry accessed.
// - Direction zero copies the data register into the selected entry.
// - Direction one loads the selected entry, except its FIFO block pointer, into the data register.
// - Busy rises on the launching write, holds during the access, then clears.
// - The nine-bit FIFO block pointer is write-only and loaded before writing.
// - Transfer available shows FIFO threshold or end-of-packet, refreshed only by reads.
// - Delineate enable turns on flag delineation and de-stuffing.
// - Delineate disabled means no delineation, de-stuffing or CRC check.
// - FCS discard with nonzero CRC select drops CRC bytes, else they are stored.
// - The descriptor byte count matches whether CRC bytes were kept.
// - FCS discard has no effect while delineation is off.
// - CRC select 00 none, 01 CCITT, 10 CRC-32, 11 reserved; ignored without delineation.
// - Provision enable processes the channel's data; cleared it ignores it.
// - Writable data fields other than the FIFO block pointer read back the last write until an indirect read completes.
// - Request threshold is transfer size plus one sixteen-byte blocks, or end-of-packet.
module rhcpa_top
  import rhcpa_pkg::*;
#(
  parameter int CHANNELS = 32
) (
  input  wire  logic                clk,
  input  wire  logic                rstn,
  input  wire  logic [11:0]         s_axi_awaddr,
  input  wire  logic                s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire  logic [31:0]         s_axi_wdata,
  input  wire  logic [3:0]          s_axi_wstrb,
  input  wire  logic                s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire  logic                s_axi_bready,
  input  wire  logic [11:0]         s_axi_araddr,
  input  wire  logic                s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire  logic                s_axi_rready,
  input  wire  logic [4:0]          ctrl_channel_number,
  output rhcpa_ctrl_t               ctrl_out,
  output logic [8:0]                ctrl_fifo_block_pointer,
  input  wire  logic [CHANNELS-1:0] fifo_eop,
  input  wire  logic [CHANNELS-1:0][11:0] fifo_bytes,
  input  wire  logic [4:0]          desc_payload_len,
  input  wire  logic                desc_fcs_len4,
  output logic [5:0]                desc_byte_count
);
  rhcpa_entry_t mem_q [CHANNELS];
  logic [2:0]   transfer_size_mem_q [CHANNELS];
  logic [4:0]   channel_number_q;
  logic         dir_q;
  logic         busy_q;
  logic [1:0]   cnt_q;
  rhcpa_entry_t data_q;
  logic         transfer_available_q;
  logic [2:0]   transfer_size_q;
  logic         aw_held_q;
  logic [11:0]  awaddr_q;
  logic         w_held_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         bvalid_q;
  logic [1:0]   bresp_q;
  logic         rvalid_q;
  logic [31:0]  rdata_q;
  logic [1:0]   rresp_q;

  // Write address and data are latched independently, then committed together.
  wire         aw_take  = s_axi_awvalid && !aw_held_q && !bvalid_q;
  wire         w_take   = s_axi_wvalid && !w_held_q && !bvalid_q;
  wire         aw_have  = aw_held_q || aw_take;
  wire         w_have   = w_held_q || w_take;
  wire         wr_fire  = aw_have && w_have && !bvalid_q;
  wire [11:0]  wr_addr  = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0]  wr_data  = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0]   wr_strb  = w_held_q ? wstrb_q : s_axi_wstrb;
  wire         wr_sel   = wr_fire && wr_addr == RHCPA_SEL_OFF;
  wire         wr_d1    = wr_fire && wr_addr == RHCPA_DATA1_OFF;
  wire         wr_xf    = wr_fire && wr_addr == RHCPA_TRANSFER_SIZE_OFF;
  wire         wr_ok    = wr_sel || wr_d1 || wr_xf;
  wire         lo_en    = wr_strb[0];
  wire         hi_en    = wr_strb[1];
  wire         launch   = wr_sel && hi_en && lo_en && !busy_q;
  wire         done     = busy_q && cnt_q == 2'(RHCPA_ACCESS_CYCLES - 1);
  wire         rd_take  = s_axi_arvalid && !rvalid_q;
  wire [31:0]  sel_word = {16'h0000, busy_q, dir_q, 9'h000, channel_number_q};
  wire [31:0]  d1_word  = {16'h0000, data_q.provision_enable, data_q.crc, data_q.fcs_discard, data_q.delineate_enable,
                           transfer_available_q, 10'h000};
  wire [31:0]  xf_word  = {29'h0000_0000, transfer_size_q};
  wire         rd_sel   = s_axi_araddr == RHCPA_SEL_OFF;
  wire         rd_d1    = s_axi_araddr == RHCPA_DATA1_OFF;
  wire         rd_xf    = s_axi_araddr == RHCPA_TRANSFER_SIZE_OFF;
  wire [31:0]  rd_word  = rd_sel ? sel_word : rd_d1 ? d1_word : rd_xf ? xf_word : 32'h0000_0000;

  // Threshold per channel: (transfer size + 1) blocks, or any end-of-packet waiting.
  logic [CHANNELS-1:0] transfer_available_live;
  for (genvar g = 0; g < CHANNELS; g++) begin : g_thr
    wire [11:0] thr = 12'((32'(transfer_size_mem_q[g]) + 1) * RHCPA_BLOCK_BYTES);
    assign transfer_available_live[g] = fifo_eop[g] || fifo_bytes[g] >= thr;
  end

  // Per-channel controls driven into the receive HDLC processor.
  rhcpa_entry_t cur;
  assign cur                  = mem_q[ctrl_channel_number];
  assign ctrl_fifo_block_pointer            = cur.fifo_block_pointer;
  assign ctrl_out.enable      = cur.provision_enable;
  assign ctrl_out.delineate   = cur.provision_enable && cur.delineate_enable;
  assign ctrl_out.crc_check   = (cur.provision_enable && cur.delineate_enable) ? cur.crc : RHCPA_CRC_NONE;
  assign ctrl_out.discard_fcs = cur.provision_enable && cur.delineate_enable && cur.fcs_discard
                                && cur.crc != RHCPA_CRC_NONE;
  wire [5:0] fcs_len = desc_fcs_len4 ? 6'd4 : 6'd2;
  assign desc_byte_count = {1'b0, desc_payload_len}
                           + (ctrl_out.discard_fcs || !ctrl_out.delineate ? 6'd0 : fcs_len);

  assign s_axi_awready = aw_take;
  assign s_axi_wready  = w_take;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RHCPA_RESP_OKAY;
    end else begin
      if (aw_take && !wr_fire) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take && !wr_fire) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? RHCPA_RESP_OKAY : RHCPA_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RHCPA_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= (rd_sel || rd_d1 || rd_xf) ? RHCPA_RESP_OKAY : RHCPA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Select register and access sequencer.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      channel_number_q <= 5'h00;
      dir_q  <= 1'b0;
      busy_q <= 1'b0;
      cnt_q  <= 2'd0;
    end else if (launch) begin
      channel_number_q <= wr_data[RHCPA_CHANNEL_NUMBER_LSB +: 5];
      dir_q  <= wr_data[RHCPA_DIR_BIT];
      busy_q <= 1'b1;
      cnt_q  <= 2'd0;
    end else if (done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 2'd1;
    end
  end

  // Data registers: software writes hold until a completed indirect read.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_q   <= RHCPA_ENTRY_RST;
      transfer_available_q <= 1'b0;
      transfer_size_q   <= 3'd0;
    end else if (done && dir_q) begin
      data_q.provision_enable  <= mem_q[channel_number_q].provision_enable;
      data_q.crc   <= mem_q[channel_number_q].crc;
      data_q.fcs_discard <= mem_q[channel_number_q].fcs_discard;
      data_q.delineate_enable <= mem_q[channel_number_q].delineate_enable;
      transfer_available_q     <= transfer_available_live[channel_number_q];
      transfer_size_q       <= transfer_size_mem_q[channel_number_q];
    end else begin
      if (wr_d1 && lo_en) data_q.fifo_block_pointer[7:0] <= wr_data[RHCPA_FIFO_BLOCK_POINTER_LSB +: 8];
      if (wr_d1 && hi_en) data_q.fifo_block_pointer[8] <= wr_data[RHCPA_FIFO_BLOCK_POINTER_LSB + 8];
      if (wr_d1 && hi_en) begin
        data_q.provision_enable  <= wr_data[RHCPA_PROVISION_ENABLE_BIT];
        data_q.crc   <= rhcpa_crc_t'(wr_data[RHCPA_CRC_LSB +: 2]);
        data_q.fcs_discard <= wr_data[RHCPA_FCS_DISCARD_BIT];
        data_q.delineate_enable <= wr_data[RHCPA_DELINEATE_ENABLE_BIT];
      end
      if (wr_xf && lo_en) transfer_size_q <= wr_data[2:0];
    end
  end

  // Provisioning memory, written at the end of an indirect write.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        mem_q[i]      <= RHCPA_ENTRY_RST;
        transfer_size_mem_q[i] <= 3'd0;
      end
    end else if (done && !dir_q) begin
      mem_q[channel_number_q]      <= data_q;
      transfer_size_mem_q[channel_number_q] <= transfer_size_q;
    end
  end
endmodule : rhcpa_top
`default_nettype wire

// >>> tb/rhcpa_asserts.sv
// Port checker for the channel provisioning access block.
// Bound to every rhcpa_top instance; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module rhcpa_asserts
  import rhcpa_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire rhcpa_ctrl_t ctrl_out,
  input wire logic [4:0]  desc_payload_len,
  input wire logic        desc_fcs_len4,
  input wire logic [5:0]  desc_byte_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_bdue; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_wref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_rref; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_rdue; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_delineate_enable; !ctrl_out.delineate |-> ctrl_out.crc_check == RHCPA_CRC_NONE && !ctrl_out.discard_fcs; endproperty
  property p_provision_enable; !ctrl_out.enable |-> !ctrl_out.delineate; endproperty
  property p_desc; desc_byte_count == {1'b0, desc_payload_len} ||
    desc_byte_count == desc_payload_len + (desc_fcs_len4 ? 6'd4 : 6'd2); endproperty
  a_bdue: assert property (p_bdue) else $error("write response late");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_wref: assert property (p_wref) else $error("write taken while response pending");
  a_rref: assert property (p_rref) else $error("read taken while data pending");
  a_rdue: assert property (p_rdue) else $error("read data late");
  a_rhold: assert property (p_rhold) else $error("read data changed while held");
  a_delineate_enable: assert property (p_delineate_enable) else $error("crc or discard active without delineation");
  a_provision_enable: assert property (p_provision_enable) else $error("unprovisioned channel processed");
  a_desc: assert property (p_desc) else $error("descriptor byte count wrong");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_fcs_discard: cover property (ctrl_out.discard_fcs);
endmodule : rhcpa_asserts
bind rhcpa_top rhcpa_asserts u_chk (.*);
`default_nettype wire

// >>> tb/rhcpa_top_test.sv
// Self-checking bench for the channel provisioning access block.
// Drives AXI4-Lite and the channel status inputs directly.
`timescale 1ns/1ps
`default_nettype none
module rhcpa_top_test;
  import rhcpa_pkg::*;
  logic clk = 0, rstn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [4:0] ctrl_channel_number = 0, desc_payload_len = 5'd10;
  rhcpa_ctrl_t ctrl_out;
  logic [8:0] ctrl_fifo_block_pointer;
  logic [31:0] fifo_eop = 0;
  logic [31:0][11:0] fifo_bytes = '0;
  logic desc_fcs_len4 = 0;
  logic [5:0] desc_byte_count;
  int fail_count = 0, samples_checked = 0;
  rhcpa_top u_dut (.*);
  always #50 clk = ~clk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    @(negedge clk); while (!(s_axi_awready && s_axi_wready)) @(negedge clk);
    @(posedge clk); s_axi_awvalid <= 0; s_axi_wvalid <= 0;
    @(negedge clk); while (!s_axi_bvalid) @(negedge clk);
    chk("bresp", er, s_axi_bresp);
    @(posedge clk); s_axi_bready <= 0;
  endtask : wr
  task automatic rd(logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    @(negedge clk); while (!s_axi_arready) @(negedge clk);
    @(posedge clk); s_axi_arvalid <= 0;
    @(negedge clk); while (!s_axi_rvalid) @(negedge clk);
    rv = s_axi_rdata; rr = s_axi_rresp;
    @(posedge clk); s_axi_rready <= 0;
  endtask : rd
  task automatic pv(logic [4:0] c, logic [31:0] d1, logic dir);
    wr(RHCPA_DATA1_OFF, d1, RHCPA_RESP_OKAY);
    wr(RHCPA_SEL_OFF, {17'h0_0000, dir, 9'h000, c}, RHCPA_RESP_OKAY);
    for (int i = 0; i < 20; i++) begin
      rd(RHCPA_SEL_OFF);
      if (rv[15] === 1'b0) break;
    end
    chk("busy", 0, rv[15]);
  endtask : pv
  task automatic see(logic [4:0] c, logic [31:0] ec, logic [31:0] en);
    ctrl_channel_number <= c;
    @(negedge clk);
    chk("ctrl_out", ec, ctrl_out);
    chk("desc", en, desc_byte_count);
  endtask : see
  task automatic t_write;
    rd(RHCPA_SEL_OFF); chk("sel rst", 0, rv);
    wr(RHCPA_TRANSFER_SIZE_OFF, 1, RHCPA_RESP_OKAY);
    pv(5, 32'h0000_b9a5, 0);
    rd(RHCPA_DATA1_OFF); chk("data1", 32'h0000_b800, rv);
    see(5, 32'h0000_001b, 10);
    chk("fifo_block_pointer", 9'h1a5, ctrl_fifo_block_pointer);
  endtask : t_write
  task automatic t_read;
    fifo_bytes[5] <= 12'd32; fifo_eop[6] <= 1;
    pv(5, 0, 1); rd(RHCPA_DATA1_OFF); chk("rd5", 32'h0000_bc00, rv);
    rd(RHCPA_TRANSFER_SIZE_OFF); chk("transfer_size", 1, rv);
    fifo_bytes[5] <= 12'd31;
    pv(5, 0, 1); rd(RHCPA_DATA1_OFF); chk("rd5 low", 32'h0000_b800, rv);
    pv(6, 0, 1); rd(RHCPA_DATA1_OFF); chk("rd6 eop", 32'h0000_0400, rv);
  endtask : t_read
  task automatic t_gate;
    fork
      wr(RHCPA_SEL_OFF, 32'h0000_4009, RHCPA_RESP_OKAY);
      begin @(posedge clk); rd(RHCPA_SEL_OFF); end
    join
    chk("busy high", 32'h0000_c009, rv);
    rd(RHCPA_SEL_OFF); chk("busy low", 32'h0000_4009, rv);
    desc_fcs_len4 <= 1;
    for (int c = 0; c < 4; c++) begin
      pv(5'(10 + c), 32'h0000_9800 | (c << 13), 0);
      see(5'(10 + c), 32'h0000_0018 | (c << 1) | (c != 0), (c != 0) ? 10 : 14);
    end
    pv(20, 32'h0000_f000, 0); see(20, 32'h0000_0010, 10);
    pv(21, 32'h0000_7800, 0); see(21, 0, 10);
    wr(12'h300, 0, RHCPA_RESP_SLVERR);
    rd(12'h300); chk("rresp", RHCPA_RESP_SLVERR, rr); chk("rdata", 0, rv);
  endtask : t_gate
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    #2_000_000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    t_write();
    t_read();
    t_gate();
    finish_test();
  end
endmodule : rhcpa_top_test
`default_nettype wire
